/* File: logic/pfs_supervisor.sv */
// Fault supervisor, sequencer and strap decode for a multi-rail power unit.
// Assumes comparator flags and straps arrive asynchronously on pins and
// software uses a zero-wait APB slave on the same 20 MHz clock.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module pfs_supervisor (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Pins and comparator flags
    input wire pfs_pkg::pfs_pins_type I_PINS,
    // Rail controls
    output logic [2:0] O_BUCK_EN,
    output logic [2:0] O_HS_ALLOW,
    output logic [2:0] O_LS_HOLD,
    output logic O_LINEAR_EN,
    output logic O_OUT_DISCHARGE,
    output logic O_GATE_EN,
    output logic O_EXTERNAL_ENABLE_FIRST,
    output logic O_SENSE_DISCHARGE,
    output logic O_SLEEP_MODE,
    output logic O_CORE_SRC_BUS,
    output logic [5:0] O_CORE_VCODE,
    // Open-drain power-good pin
    output logic O_POWER_GOOD_OUT,
    output logic O_POWER_GOOD_OE
);
    import pfs_pkg::*;

    // ==========================================================
    // Decode helpers
    function automatic logic [5:0] strap_code(input logic [2:0] s);
        // Order: reference_out_strap, reference_adjust_strap, core_reference_in
        case (s[1:0])
            2'b00: strap_code = VCODE_0V9;
            2'b01: strap_code = VCODE_1V1;
            2'b10: strap_code = VCODE_1V2;
            default: strap_code = VCODE_1V0;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == ADDR_CTRL) || (a == ADDR_VSET) || (a == ADDR_STATUS)
            || (a == ADDR_OUTPUTS);
    endfunction

    // ==========================================================
    // Pin synchroniser
    pfs_pins_type sync1_q, sync2_q, pins;
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= I_PINS;
            sync2_q <= sync1_q;
        end
    end
    assign pins = sync2_q;

    logic por_ok, vin_ov_raw;
    assign por_ok = pins.supply_sel ? pins.por_5v : pins.por_3v3;
    assign vin_ov_raw = pins.supply_sel ? pins.vin_ov_5v : pins.vin_ov_3v3;

    // ==========================================================
    // De-glitch counters: {input ov, buck ov[2:0], buck uv[2:0]}
    logic [6:0] dg_raw, dg;
    // A rail that is off reads under-voltage; masking it keeps a re-enabled rail from latching
    assign dg_raw = {vin_ov_raw, pins.buck_ov, pins.buck_uv & O_BUCK_EN};

    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_dg
            logic [DG_W-1:0] cnt_q, cnt_d;
            always_comb begin
                if (!dg_raw[g]) begin
                    cnt_d = '0;
                end else if (cnt_q < DG_W'(DEGLITCH_CYC)) begin
                    cnt_d = cnt_q + DG_W'(1);
                end else begin
                    cnt_d = cnt_q;
                end
            end
            always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
                if (!I_RSTN) begin
                    cnt_q <= '0;
                end else begin
                    cnt_q <= cnt_d;
                end
            end
            assign dg[g] = (cnt_q == DG_W'(DEGLITCH_CYC));
        end
    endgenerate

    logic [2:0] buck_uv_dg, buck_ov_dg;
    logic vin_ov_dg;
    assign buck_uv_dg = dg[2:0];
    assign buck_ov_dg = dg[5:3];
    assign vin_ov_dg = dg[6];

    // ==========================================================
    // State
    pfs_state_type state_q, state_d;
    logic [1:0] seq_idx_q, seq_idx_d;
    logic [STEP_W-1:0] step_q, step_d;
    logic [2:0] uv_latch_q, uv_latch_d;
    logic lin_latch_q, lin_latch_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [5:0] vset_q, vset_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic [2:0] buck_en_d, hs_d, ls_d;
    logic lin_en_d, dis_d, gate_d, ext_d, sleep_d, pg_d;
    logic [3:0] rails_on;
    logic setup, wr;

    assign setup = I_PSEL && !I_PENABLE;
    assign wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;

    always_comb begin
        state_d = state_q;
        seq_idx_d = seq_idx_q;
        step_d = step_q;
        uv_latch_d = uv_latch_q;
        lin_latch_d = lin_latch_q;
        ctrl_d = ctrl_q;
        vset_d = vset_q;

        // Sequencer with fault priority: lockout, uv latch, input ov, heat
        if (!por_ok) begin
            state_d = ST_OFF;
            uv_latch_d = '0;
            lin_latch_d = 1'b0;
            vset_d = strap_code(pins.strap);
        end else begin
            if (state_q == ST_ON) begin
                uv_latch_d = uv_latch_q | (buck_uv_dg & O_BUCK_EN);
                lin_latch_d = lin_latch_q | (pins.linear_uv && O_LINEAR_EN);
            end
            if (uv_latch_d != 3'h0) begin
                state_d = ST_UV_LATCH;
            end else if (vin_ov_dg) begin
                state_d = ST_VIN_OV;
            end else if (pins.die_hot) begin
                state_d = ST_OT_WAIT;
            end else begin
                case (state_q)
                    ST_OFF: begin
                        state_d = ST_SEQ;
                        seq_idx_d = 2'h0;
                        step_d = '0;
                    end
                    ST_SEQ: begin
                        if (step_q == STEP_W'(SEQ_STEP_CYC - 1)) begin
                            step_d = '0;
                            seq_idx_d = seq_idx_q + 2'h1;
                            if (seq_idx_q == 2'h3) begin
                                state_d = ST_ON;
                            end
                        end else begin
                            step_d = step_q + STEP_W'(1);
                        end
                    end
                    ST_ON: state_d = ST_ON;
                    ST_UV_LATCH: state_d = ST_UV_LATCH;
                    ST_OT_WAIT, ST_VIN_OV: begin
                        if (pins.die_cool) begin
                            state_d = ST_SEQ;
                            seq_idx_d = 2'h0;
                            step_d = '0;
                        end
                    end
                    default: state_d = ST_OFF;
                endcase
            end
        end

        // Rails follow the next state so they drop in the cycle discharge starts
        case (state_d)
            ST_ON: rails_on = 4'hF;
            ST_SEQ: rails_on = 4'((5'h2 << seq_idx_d) - 5'h1);
            default: rails_on = 4'h0;
        endcase
        buck_en_d = rails_on[2:0] & ~buck_ov_dg;
        lin_en_d = rails_on[3] && !lin_latch_d;
        hs_d = buck_en_d & ~pins.valley_lim;
        ls_d = buck_en_d & pins.valley_lim;
        dis_d = !por_ok || (uv_latch_d != 3'h0) || lin_latch_d;
        gate_d = por_ok && !vin_ov_dg && (state_d != ST_VIN_OV);
        sleep_d = !pins.standby_n;
        // Sleep drops the external enable unless software keeps it alive
        ext_d = (state_q == ST_ON) && ctrl_q[CTRL_EXT_EN]
            && !(sleep_d && !ctrl_q[CTRL_EXT_ALIVE]);
        pg_d = (state_q == ST_ON) && (buck_ov_dg == 3'h0) && por_ok;

        // APB: data prepared in setup, answered in the first access cycle
        pready_d = setup;
        pslverr_d = setup && !addr_ok(I_PADDR);
        prdata_d = 32'h0;
        if (setup) begin
            case (I_PADDR)
                ADDR_CTRL: prdata_d = {29'h0, ctrl_q};
                ADDR_VSET: prdata_d = {26'h0, vset_q};
                ADDR_STATUS: prdata_d = {17'h0, por_ok, pins.strap, sleep_d, O_POWER_GOOD_OE,
                    buck_ov_dg, vin_ov_dg, state_q == ST_OT_WAIT, lin_latch_q,
                    uv_latch_q};
                ADDR_OUTPUTS: prdata_d = {21'h0, O_SENSE_DISCHARGE, O_EXTERNAL_ENABLE_FIRST,
                    O_GATE_EN, O_OUT_DISCHARGE, O_LINEAR_EN, O_BUCK_EN, 3'(state_q)};
                default: prdata_d = 32'h0;
            endcase
        end
        if (wr && I_PADDR == ADDR_CTRL) begin
            ctrl_d = I_PWDATA[2:0];
        end
        if (wr && I_PADDR == ADDR_VSET && por_ok) begin
            // Codes past 1.3 V saturate rather than wrap
            vset_d = (I_PWDATA[5:0] > VCODE_MAX) ? VCODE_MAX : I_PWDATA[5:0];
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_q <= ST_OFF;
            seq_idx_q <= 2'h0;
            step_q <= '0;
            uv_latch_q <= 3'h0;
            lin_latch_q <= 1'b0;
            ctrl_q <= CTRL_RST;
            vset_q <= VCODE_RST;
            O_PRDATA <= 32'h0;
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_BUCK_EN <= 3'h0;
            O_HS_ALLOW <= 3'h0;
            O_LS_HOLD <= 3'h0;
            O_LINEAR_EN <= 1'b0;
            O_OUT_DISCHARGE <= 1'b1;
            O_GATE_EN <= 1'b0;
            O_EXTERNAL_ENABLE_FIRST <= 1'b0;
            O_SENSE_DISCHARGE <= 1'b1;
            O_SLEEP_MODE <= 1'b0;
            O_CORE_SRC_BUS <= 1'b0;
            O_CORE_VCODE <= VCODE_RST;
            O_POWER_GOOD_OUT <= 1'b0;
            O_POWER_GOOD_OE <= 1'b1;
        end else begin
            state_q <= state_d;
            seq_idx_q <= seq_idx_d;
            step_q <= step_d;
            uv_latch_q <= uv_latch_d;
            lin_latch_q <= lin_latch_d;
            ctrl_q <= ctrl_d;
            vset_q <= vset_d;
            O_PRDATA <= prdata_d;
            O_PREADY <= pready_d;
            O_PSLVERR <= pslverr_d;
            O_BUCK_EN <= buck_en_d;
            O_HS_ALLOW <= hs_d;
            O_LS_HOLD <= ls_d;
            O_LINEAR_EN <= lin_en_d;
            O_OUT_DISCHARGE <= dis_d;
            O_GATE_EN <= gate_d;
            O_EXTERNAL_ENABLE_FIRST <= ext_d;
            O_SENSE_DISCHARGE <= !ext_d;
            O_SLEEP_MODE <= sleep_d;
            O_CORE_SRC_BUS <= ctrl_d[CTRL_BUS_SRC];
            O_CORE_VCODE <= vset_d;
            O_POWER_GOOD_OUT <= 1'b0;
            O_POWER_GOOD_OE <= !pg_d;
        end
    end

endmodule // pfs_supervisor

/* File: logic/pfs_pkg.sv */
// Constants and types shared by the rail fault supervisor.
// Assumes a 20 MHz system clock and 32-bit APB register access.
package pfs_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int DEGLITCH_NS = 1000;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SEQ_STEP_US = 100;
    localparam int SEQ_STEP_CYC = SEQ_STEP_US * (CLK_HZ / 1_000_000);
    localparam int DG_W = 8;
    localparam int STEP_W = 12;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_VSET = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_OUTPUTS = 12'h00C;
    localparam int CTRL_BUS_SRC = 0;
    localparam int CTRL_EXT_EN = 1;
    localparam int CTRL_EXT_ALIVE = 2;
    localparam logic [2:0] CTRL_RST = 3'h2;

    // ==========================================================
    // Core rail code: 0.7 V plus 10 mV per step
    localparam logic [5:0] VCODE_0V9 = 6'h14;
    localparam logic [5:0] VCODE_1V0 = 6'h1E;
    localparam logic [5:0] VCODE_1V1 = 6'h28;
    localparam logic [5:0] VCODE_1V2 = 6'h32;
    localparam logic [5:0] VCODE_MAX = 6'h3C;
    localparam logic [5:0] VCODE_RST = VCODE_0V9;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [2:0] strap;
        logic standby_n;
        logic supply_sel;
        logic por_5v;
        logic por_3v3;
        logic vin_ov_5v;
        logic vin_ov_3v3;
        logic [2:0] buck_uv;
        logic [2:0] buck_ov;
        logic linear_uv;
        logic die_hot;
        logic die_cool;
        logic [2:0] valley_lim;
    } pfs_pins_type;

    typedef enum logic [2:0] {
        ST_OFF, ST_SEQ, ST_ON, ST_UV_LATCH, ST_OT_WAIT, ST_VIN_OV
    } pfs_state_type;

endpackage

/* File: test/pfs_supervisor_assertions.sv */
// Concurrent checks on the ports of the rail fault supervisor.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module pfs_supervisor_assertions (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    // Watched ports
    input wire pfs_pkg::pfs_pins_type I_PINS,
    input wire logic [2:0] O_BUCK_EN,
    input wire logic O_LINEAR_EN,
    input wire logic O_OUT_DISCHARGE,
    input wire logic O_GATE_EN,
    input wire logic O_EXTERNAL_ENABLE_FIRST,
    input wire logic O_SENSE_DISCHARGE,
    input wire logic O_SLEEP_MODE,
    input wire logic [5:0] O_CORE_VCODE,
    input wire logic O_POWER_GOOD_OE
);
    import pfs_pkg::*;
    logic [5:0] ov_q, ov_d, vin_q, vin_d, strap_code;
    logic por_sel, vin_sel;
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RSTN);
    // ==========================================================
    // Helpers: consecutive cycles a comparator pin has been high
    always_comb begin
        por_sel = I_PINS.supply_sel ? I_PINS.por_5v : I_PINS.por_3v3;
        vin_sel = I_PINS.supply_sel ? I_PINS.vin_ov_5v : I_PINS.vin_ov_3v3;
        ov_d = !I_PINS.buck_ov[1] ? 6'h00 : (ov_q == 6'h3F ? ov_q : ov_q + 6'h01);
        vin_d = !vin_sel ? 6'h00 : (vin_q == 6'h3F ? vin_q : vin_q + 6'h01);
        case (I_PINS.strap[1:0])
            2'h0: strap_code = VCODE_0V9;
            2'h1: strap_code = VCODE_1V1;
            2'h2: strap_code = VCODE_1V2;
            default: strap_code = VCODE_1V0;
        endcase
    end
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ov_q <= 6'h00;
            vin_q <= 6'h00;
        end else begin
            ov_q <= ov_d;
            vin_q <= vin_d;
        end
    end
    // ==========================================================
    // Properties
    AST_STRAP: assert property ((!por_sel && $stable(I_PINS.strap)) [*6] |->
        O_CORE_VCODE == strap_code) else $error("core code differs from strap default");
    AST_SLEEP: assert property ((!I_PINS.standby_n) [*6] |-> O_SLEEP_MODE)
        else $error("standby low without sleep mode");
    AST_OV_GLITCH: assert property ($rose(I_PINS.buck_ov[1]) && O_BUCK_EN[1] |->
        O_BUCK_EN[1] [*8]) else $error("rail dropped before over-voltage de-glitch");
    AST_OV_RAIL: assert property (ov_q >= 6'd30 |-> !O_BUCK_EN[1] && O_POWER_GOOD_OE)
        else $error("over-voltage rail still on or power-good released");
    AST_HOT: assert property ($rose(I_PINS.die_hot) |->
        ##[2:6] (O_BUCK_EN == 3'h0 && !O_LINEAR_EN)) else $error("rails on while die hot");
    AST_DISCH: assert property (O_OUT_DISCHARGE |-> !O_LINEAR_EN)
        else $error("discharge while linear rail enabled");
    AST_SENSE: assert property (O_SENSE_DISCHARGE != O_EXTERNAL_ENABLE_FIRST)
        else $error("sense discharge does not oppose external enable");
    AST_VIN_OV: assert property (vin_q >= 6'd30 |-> !O_GATE_EN && O_BUCK_EN == 3'h0)
        else $error("input over-voltage left gate or rails on");
endmodule // pfs_supervisor_assertions

/* File: test/pfs_far_model.sv */
// Far side: board straps, host standby line and rail comparators.
// Bench drives a command word; the model watches the rail enables.
`timescale 1ns/1ps
module pfs_far_model (
    // Commands and rail enables
    input wire pfs_pkg::pfs_pins_type i_cmd,
    input wire logic [2:0] i_buck_en,
    input wire logic i_linear_en,
    // Pins seen by the supervisor
    output pfs_pkg::pfs_pins_type o_pins
);
    import pfs_pkg::*;
    always_comb begin
        o_pins = i_cmd;
        // A rail that is off reads below threshold, as a real comparator does
        o_pins.buck_uv = i_cmd.buck_uv | ~i_buck_en;
        o_pins.linear_uv = i_cmd.linear_uv | ~i_linear_en;
        // The 5 V thresholds sit above the 3.3 V ones
        o_pins.por_3v3 = i_cmd.por_3v3 | i_cmd.por_5v;
        o_pins.vin_ov_3v3 = i_cmd.vin_ov_3v3 | i_cmd.vin_ov_5v;
        o_pins.die_cool = i_cmd.die_cool & ~i_cmd.die_hot;
    end
endmodule // pfs_far_model

/* File: test/tb_top.sv */
// Self-checking bench for the rail fault supervisor.
// Assumes the far-side model and the checker are compiled first.
`timescale 1ns/1ps
module tb_top;
    import pfs_pkg::*;
    logic clk, rstn, psel, pen, pwr, rdy, serr, lin, odis, gate, ext, sdis, slp, bsrc, pgo, pgoe, err;
    logic [11:0] addr;
    logic [31:0] wdat, prd, rd;
    logic [2:0] buck, hs, ls;
    logic [5:0] vcode;
    pfs_pins_type cmd, pins;
    int error_cnt = 0;
    int num_checks = 0;
    pfs_far_model i_far (.i_cmd(cmd), .i_buck_en(buck), .i_linear_en(lin), .o_pins(pins));
    pfs_supervisor i_dut (.I_CLOCK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wdat), .O_PRDATA(prd), .O_PREADY(rdy),
        .O_PSLVERR(serr), .I_PINS(pins), .O_BUCK_EN(buck), .O_HS_ALLOW(hs), .O_LS_HOLD(ls),
        .O_LINEAR_EN(lin), .O_OUT_DISCHARGE(odis), .O_GATE_EN(gate),
        .O_EXTERNAL_ENABLE_FIRST(ext), .O_SENSE_DISCHARGE(sdis), .O_SLEEP_MODE(slp),
        .O_CORE_SRC_BUS(bsrc), .O_CORE_VCODE(vcode), .O_POWER_GOOD_OUT(pgo),
        .O_POWER_GOOD_OE(pgoe));
    // ==========================================================
    // Shared tasks
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %0h seen %0h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Waits for the linear rail, then for the last sequencer step to reach ON
    task automatic wait_lin();
        int k;
        for (k = 0; k < 12000 && lin !== 1'b1; k++)
            @(negedge clk);
        chk("linear_enable", 32'h1, {31'h0, lin});
        if (lin !== 1'b1)
            final_report();
        cyc(SEQ_STEP_CYC + 10);
    endtask
    // Ready is looked at mid-cycle so the edge that ends the access is not raced
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (k = 0; k < 16 && rdy !== 1'b1; k++)
            @(negedge clk);
        rd = prd;
        err = serr;
        chk("bus_ready", 32'h1, {31'h0, rdy});
        if (k == 16)
            final_report();
        @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
        // One idle edge so a following call never reassigns the strobes in this step
        @(posedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_straps();
        logic [5:0] exp [4];
        exp = '{VCODE_0V9, VCODE_1V1, VCODE_1V2, VCODE_1V0};
        for (int i = 0; i < 4; i++) begin
            cmd.strap <= {1'b1, i[1:0]};
            cyc(8);
            chk("strap_code", {26'h0, exp[i]}, {26'h0, vcode});
        end
        cmd.strap <= 3'h0;
        cyc(8);
        chk("lockout_discharge", 32'h3, {30'h0, odis, sdis});
    endtask
    task automatic t_power();
        cmd.supply_sel <= 1'b1;
        cmd.por_3v3 <= 1'b1;
        cyc(40);
        chk("rails_low_supply", 32'h0, {29'h0, buck});
        cmd.por_5v <= 1'b1;
        wait_lin();
        chk("rails_up", 32'h7, {29'h0, buck});
        chk("power_good", 32'h0, {30'h0, pgo, pgoe});
    endtask
    task automatic t_bus();
        apb(1'b1, ADDR_VSET, 32'h3F);
        apb(1'b0, ADDR_VSET, 32'h0);
        chk("vset_clamp", {26'h0, VCODE_MAX}, rd);
        apb(1'b1, ADDR_VSET, 32'h1E);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, ADDR_CTRL, 32'h1);
        cyc(4);
        chk("bus_core", 32'h7B, {24'h0, vcode, bsrc, sdis});
        apb(1'b1, ADDR_CTRL, 32'h3);
        cyc(4);
        chk("ext_enable", 32'h2, {30'h0, ext, sdis});
    endtask
    task automatic t_pins();
        cmd.standby_n <= 1'b0;
        cmd.valley_lim <= 3'h1;
        cyc(8);
        chk("sleep_valley", 32'h6, {29'h0, slp, ls[0], hs[0]});
        chk("sleep_ext_off", 32'h1, {30'h0, ext, sdis});
        apb(1'b1, ADDR_CTRL, 32'h7);
        cyc(4);
        chk("sleep_ext_alive", 32'h2, {30'h0, ext, sdis});
        cmd.standby_n <= 1'b1;
        cmd.valley_lim <= 3'h0;
        cyc(8);
        chk("wake_valley", 32'h1, {29'h0, slp, ls[0], hs[0]});
    endtask
    task automatic t_ov();
        cmd.buck_ov[1] <= 1'b1;
        cyc(5);
        cmd.buck_ov[1] <= 1'b0;
        cyc(30);
        chk("ov_glitch", 32'h7, {29'h0, buck});
        cmd.buck_ov[1] <= 1'b1;
        cyc(40);
        chk("ov_rail_off", 32'hB, {28'h0, buck, pgoe});
        cmd.buck_ov[1] <= 1'b0;
        cyc(40);
        chk("ov_release", 32'hE, {28'h0, buck, pgoe});
    endtask
    task automatic t_hot();
        cmd.die_hot <= 1'b1;
        cmd.die_cool <= 1'b0;
        cyc(8);
        chk("hot_off", 32'h0, {28'h0, buck, lin});
        cmd.die_hot <= 1'b0;
        cyc(50);
        chk("warm_off", 32'h0, {28'h0, buck, lin});
        cmd.die_cool <= 1'b1;
        wait_lin();
    endtask
    task automatic t_vin();
        cmd.vin_ov_3v3 <= 1'b1;
        cyc(40);
        chk("vin_low_thr", 32'hF, {28'h0, buck, gate});
        cmd.vin_ov_5v <= 1'b1;
        cyc(40);
        chk("vin_ov_off", 32'h0, {28'h0, buck, gate});
        cmd.vin_ov_5v <= 1'b0;
        cmd.vin_ov_3v3 <= 1'b0;
        wait_lin();
        chk("vin_restart", 32'h1, {31'h0, gate});
    endtask
    task automatic t_uv();
        cmd.linear_uv <= 1'b1;
        cyc(8);
        cmd.linear_uv <= 1'b0;
        chk("linear_uv", 32'hE, {28'h0, buck, lin});
        cmd.buck_uv[0] <= 1'b1;
        cyc(40);
        cmd.buck_uv[0] <= 1'b0;
        chk("buck_uv", 32'h3, {26'h0, buck, lin, odis, pgoe});
        cyc(100);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("uv_latched", 32'h48, {rd[3:0], buck});
        cmd.por_5v <= 1'b0;
        cmd.por_3v3 <= 1'b0;
        cyc(10);
        cmd.por_5v <= 1'b1;
        wait_lin();
    endtask
    // ==========================================================
    // Clock and main sequence
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rstn, psel, pen, pwr, addr, wdat, rd, err} = '0;
        cmd = '0;
        cmd.standby_n = 1'b1;
        cmd.die_cool = 1'b1;
        cyc(6);
        rstn <= 1'b1;
        t_straps();
        t_power();
        t_bus();
        t_pins();
        t_ov();
        t_hot();
        t_vin();
        t_uv();
        final_report();
    end
endmodule // tb_top
bind pfs_supervisor pfs_supervisor_assertions i_chk (.I_CLOCK, .I_RSTN, .I_PINS, .O_BUCK_EN,
    .O_LINEAR_EN, .O_OUT_DISCHARGE, .O_GATE_EN, .O_EXTERNAL_ENABLE_FIRST, .O_SENSE_DISCHARGE,
    .O_SLEEP_MODE, .O_CORE_VCODE, .O_POWER_GOOD_OE);
